// ==== design/fwm_flash.sv ====
module fwm_flash (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic tick,
  output logic [4:0] slot,
  output logic blink
);

  // ==========================================================================
  // flash frame: 16 slots, slots 0..5 carry up to three pulses, rest is gap
  // ==========================================================================
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      slot <= 5'h00;
      blink <= 1'b0;
    end
    else if (ce && tick)
    begin
      slot <= (slot >= fwm_pkg::FWM_SLOT_LAST) ? 5'h00 : slot + 5'h01;
      blink <= ~blink;
    end
  end

endmodule // fwm_flash

// ==== design/fwm_map.sv ====
// Function
// - io words reachable as bits or words
// - holding map: write, read, parameter ranges
// - parameter address is 210h plus number minus one
// - parameters only through holding registers
// - input registers 0..FFh return reading words
// - coils map to writing word bits
// - discrete inputs map to reading word bits
// - writes to reading words are ignored
// - unused addresses read as zero
// - steady red on exception until reset
// - one red flash: config or no ip
// - three red flashes: no name, internal error
// - two green flashes on identify request
// - green normal, green/red during self test
// - network green run, flashing when stopped
// - network off without master connection
// - link off without link, green linked
// - link flashes during data exchange
module fwm_map #(
  parameter int unsigned TICK_CYC = fwm_pkg::FWM_TICK_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // network side access
  input wire logic req_valid,
  input wire logic req_write,
  input wire fwm_pkg::fwm_space_t req_space,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  // drive side
  input wire logic [7:0] io_rd_index,
  output logic [15:0] io_wr_word,
  input wire logic io_rd_we,
  input wire logic [7:0] io_rd_we_index,
  input wire logic [15:0] io_rd_wdata,
  output logic par_req,
  output logic par_write,
  output logic [15:0] par_num,
  output logic [15:0] par_wdata,
  input wire logic [15:0] par_rdata,
  // status conditions
  input wire logic exception,
  input wire logic cfg_error,
  input wire logic no_ip,
  input wire logic no_name,
  input wire logic internal_error,
  input wire logic identify,
  input wire logic self_test,
  input wire logic master_connected,
  input wire logic master_run,
  input wire logic [1:0] port_link,
  input wire logic [1:0] port_exchange,
  output fwm_pkg::fwm_led_t module_status_indicator,
  output fwm_pkg::fwm_led_t network_status_indicator,
  output fwm_pkg::fwm_led_t link_indicator_0,
  output fwm_pkg::fwm_led_t link_indicator_1
);

  logic [15:0] wr_words [fwm_pkg::FWM_WORDS];
  logic [15:0] rd_words [fwm_pkg::FWM_WORDS];
  logic tick;
  logic [4:0] slot;
  logic blink;
  logic major_latched;
  fwm_pkg::fwm_led_t next_ms;
  fwm_pkg::fwm_led_t next_ns;
  fwm_pkg::fwm_led_t next_l0;
  fwm_pkg::fwm_led_t next_l1;

  typedef enum logic [4:0] {
    FWM_ACC_NONE = 5'b00001,
    FWM_ACC_WR = 5'b00010,
    FWM_ACC_RD = 5'b00100,
    FWM_ACC_PAR = 5'b01000,
    FWM_ACC_BIT = 5'b10000
  } fwm_acc_t;

  fwm_acc_t acc;
  logic [7:0] widx;
  logic [3:0] bidx;
  logic bit_wr_space;

  // ==========================================================================
  // helpers
  // ==========================================================================
  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // n pulses at the start of a 16 slot frame, then off gap
  function automatic logic pulse(input logic [4:0] s, input logic [1:0] n);
    pulse = (s[0] == 1'b0) && (s[4:1] < {2'b00, n});
  endfunction

  function automatic fwm_pkg::fwm_led_t link_led(input logic up,
                                                 input logic xchg,
                                                 input logic b);
    if (!up)
      link_led = fwm_pkg::FWM_LED_OFF;
    else if (xchg)
      link_led = b ? fwm_pkg::FWM_LED_GREEN : fwm_pkg::FWM_LED_OFF;
    else
      link_led = fwm_pkg::FWM_LED_GREEN;
  endfunction

  // ==========================================================================
  // flash timing
  // ==========================================================================
  // one tick shared by all indicators keeps their flashing in phase
  fwm_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .tick(tick)
  );

  fwm_flash u_flash (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .tick(tick),
    .slot(slot),
    .blink(blink)
  );

  // ==========================================================================
  // address decode
  // ==========================================================================
  always_comb
  begin
    acc = FWM_ACC_NONE;
    widx = req_addr[7:0];
    bidx = 4'h0;
    bit_wr_space = 1'b0;
    case (req_space)
      fwm_pkg::FWM_SP_HOLD:
      begin
        if (in_range(req_addr, fwm_pkg::FWM_HR_WR_LO, fwm_pkg::FWM_HR_WR_HI))
          acc = FWM_ACC_WR;
        else if (in_range(req_addr, fwm_pkg::FWM_HR_RD_LO,
                          fwm_pkg::FWM_HR_RD_HI))
          acc = FWM_ACC_RD;
        else if (req_addr >= fwm_pkg::FWM_HR_PAR_BASE)
          acc = FWM_ACC_PAR;
      end
      fwm_pkg::FWM_SP_INPUT:
      begin
        if (req_addr <= fwm_pkg::FWM_IR_HI)
          acc = FWM_ACC_RD;
      end
      // bit b lives in word b[11:4] at position b[3:0]
      fwm_pkg::FWM_SP_COIL, fwm_pkg::FWM_SP_DISC:
      begin
        if (req_addr <= fwm_pkg::FWM_BIT_HI)
        begin
          acc = FWM_ACC_BIT;
          widx = req_addr[11:4];
          bidx = req_addr[3:0];
          bit_wr_space = (req_space == fwm_pkg::FWM_SP_COIL);
        end
      end
      default:
        acc = FWM_ACC_NONE;
    endcase
  end

  // ==========================================================================
  // writing words: network writes, whole or per bit
  // ==========================================================================
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < fwm_pkg::FWM_WORDS; i++)
        wr_words[i] <= fwm_pkg::FWM_WORD_RST;
    end
    else if (ce && req_valid && req_write)
    begin
      if (acc == FWM_ACC_WR)
        wr_words[widx] <= req_wdata;
      else if (acc == FWM_ACC_BIT && bit_wr_space)
        wr_words[widx][bidx] <= req_wdata[0];
      // reading words and discrete inputs drop the write
    end
  end

  // ==========================================================================
  // reading words: filled by the drive only
  // ==========================================================================
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < fwm_pkg::FWM_WORDS; i++)
        rd_words[i] <= fwm_pkg::FWM_WORD_RST;
    end
    else if (ce && io_rd_we)
      rd_words[io_rd_we_index] <= io_rd_wdata;
  end

  // ==========================================================================
  // drive view of the writing words
  // ==========================================================================
  // one cycle late, but the output comes straight from a flop
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      io_wr_word <= fwm_pkg::FWM_WORD_RST;
    else if (ce)
      io_wr_word <= wr_words[io_rd_index];
  end

  // ==========================================================================
  // parameter access and read answer
  // ==========================================================================
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      par_req <= 1'b0;
      par_write <= 1'b0;
      par_num <= 16'h0000;
      par_wdata <= 16'h0000;
    end
    else if (ce)
    begin
      par_req <= req_valid && (acc == FWM_ACC_PAR);
      // fields follow the bus every cycle; only par_req qualifies them
      par_write <= req_write;
      par_num <= req_addr - fwm_pkg::FWM_HR_PAR_BASE + 16'h0001;
      par_wdata <= req_wdata;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
    end
    else if (ce)
    begin
      // refused writes still get their answer pulse
      rsp_valid <= req_valid;
      case (acc)
        FWM_ACC_WR: rsp_rdata <= wr_words[widx];
        FWM_ACC_RD: rsp_rdata <= rd_words[widx];
        // live parameter value, drive answers combinationally
        FWM_ACC_PAR: rsp_rdata <= par_rdata;
        FWM_ACC_BIT:
          rsp_rdata <= {15'h0000, bit_wr_space ? wr_words[widx][bidx]
                                               : rd_words[widx][bidx]};
        default: rsp_rdata <= 16'h0000;
      endcase
    end
  end

  // ==========================================================================
  // indicators
  // ==========================================================================
  // exception holds until reset even if the drive drops it
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      major_latched <= 1'b0;
    else if (ce && exception)
      major_latched <= 1'b1;
  end

  // ==========================================================================
  // module status: worst condition shown
  // ==========================================================================
  // self test ranks under the major fault only, so start-up is never masked
  always_comb
  begin
    next_ms = fwm_pkg::FWM_LED_GREEN;
    if (major_latched || exception)
      next_ms = fwm_pkg::FWM_LED_RED;
    else if (self_test)
      next_ms = blink ? fwm_pkg::FWM_LED_GREEN : fwm_pkg::FWM_LED_RED;
    else if (internal_error || no_name)
      next_ms = pulse(slot, 2'h3) ? fwm_pkg::FWM_LED_RED
                                  : fwm_pkg::FWM_LED_OFF;
    else if (cfg_error || no_ip)
      next_ms = pulse(slot, 2'h1) ? fwm_pkg::FWM_LED_RED
                                  : fwm_pkg::FWM_LED_OFF;
    else if (identify)
      next_ms = pulse(slot, 2'h2) ? fwm_pkg::FWM_LED_GREEN
                                  : fwm_pkg::FWM_LED_OFF;
  end

  // ==========================================================================
  // network and link status
  // ==========================================================================
  always_comb
  begin
    if (!master_connected)
      next_ns = fwm_pkg::FWM_LED_OFF;
    else if (master_run)
      next_ns = fwm_pkg::FWM_LED_GREEN;
    else
      next_ns = blink ? fwm_pkg::FWM_LED_GREEN : fwm_pkg::FWM_LED_OFF;
  end

  // a link with traffic flashes; the pattern carries no data rate
  always_comb
  begin
    next_l0 = link_led(port_link[0], port_exchange[0], blink);
    next_l1 = link_led(port_link[1], port_exchange[1], blink);
  end

  // ==========================================================================
  // registered indicator outputs
  // ==========================================================================
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      module_status_indicator <= fwm_pkg::FWM_LED_OFF;
      network_status_indicator <= fwm_pkg::FWM_LED_OFF;
      link_indicator_0 <= fwm_pkg::FWM_LED_OFF;
      link_indicator_1 <= fwm_pkg::FWM_LED_OFF;
    end
    else if (ce)
    begin
      module_status_indicator <= next_ms;
      network_status_indicator <= next_ns;
      link_indicator_0 <= next_l0;
      link_indicator_1 <= next_l1;
    end
  end

endmodule // fwm_map

// ==== design/fwm_pkg.sv ====
package fwm_pkg;

  // ==========================================================================
  // access spaces and address map
  // ==========================================================================
  typedef enum logic [1:0] {
    FWM_SP_HOLD = 2'h0,
    FWM_SP_INPUT = 2'h1,
    FWM_SP_COIL = 2'h2,
    FWM_SP_DISC = 2'h3
  } fwm_space_t;

  localparam int FWM_WORDS = 256;
  localparam int FWM_PARAM_NUM_W = 16;
  localparam logic [15:0] FWM_HR_WR_LO = 16'h0000;
  localparam logic [15:0] FWM_HR_WR_HI = 16'h00ff;
  localparam logic [15:0] FWM_HR_RD_LO = 16'h0100;
  localparam logic [15:0] FWM_HR_RD_HI = 16'h01ff;
  localparam logic [15:0] FWM_HR_PAR_BASE = 16'h0210;
  localparam logic [15:0] FWM_IR_HI = 16'h00ff;
  localparam logic [15:0] FWM_BIT_HI = 16'h0fff;
  localparam logic [15:0] FWM_WORD_RST = 16'h0000;

  // ==========================================================================
  // indicator encodings and timing
  // ==========================================================================
  typedef enum logic [1:0] {
    FWM_LED_OFF = 2'h0,
    FWM_LED_GREEN = 2'h1,
    FWM_LED_RED = 2'h2
  } fwm_led_t;

  localparam int FWM_CLK_MHZ = 100;
  localparam int FWM_TICK_MS = 100;
  localparam int FWM_TICK_CYC = FWM_TICK_MS * 1000 * FWM_CLK_MHZ;
  localparam logic [4:0] FWM_SLOT_LAST = 5'h0f;
  localparam logic [3:0] FWM_PHASE_RST = 4'h0;

endpackage

// ==== design/fwm_tick.sv ====
module fwm_tick #(
  parameter int unsigned TICK_CYC = fwm_pkg::FWM_TICK_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  output logic tick
);

  logic [31:0] count;

  // ==========================================================================
  // prescaler
  // ==========================================================================
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      count <= 32'h0000_0000;
      tick <= 1'b0;
    end
    else if (ce)
    begin
      if (count >= 32'(TICK_CYC - 1))
      begin
        count <= 32'h0000_0000;
        tick <= 1'b1;
      end
      else
      begin
        count <= count + 32'h0000_0001;
        tick <= 1'b0;
      end
    end
  end

endmodule // fwm_tick

// ==== test/fwm_map_chk.sv ====
module fwm_map_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic req_valid,
  input wire logic req_write,
  input wire fwm_pkg::fwm_space_t req_space,
  input wire logic [15:0] req_addr,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata,
  input wire logic par_req,
  input wire logic [15:0] par_num,
  input wire logic exception,
  input wire logic master_connected,
  input wire logic master_run,
  input wire logic [1:0] port_link,
  input wire fwm_pkg::fwm_led_t module_status_indicator,
  input wire fwm_pkg::fwm_led_t network_status_indicator,
  input wire fwm_pkg::fwm_led_t link_indicator_0
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ==================================================================
  // request side
  // ==================================================================
  sequence s_take;
    ce && req_valid;
  endsequence
  sequence s_read;
    ce && req_valid && !req_write;
  endsequence
  property p_rsp;
    ce |=> rsp_valid == $past(req_valid);
  endproperty
  a_rsp: assert property (p_rsp) else $error("bad response pulse");
  property p_par;
    s_take ##0 (req_space == fwm_pkg::FWM_SP_HOLD && req_addr >= 16'h0210)
      |=> par_req && par_num == $past(req_addr) - 16'h020f;
  endproperty
  a_par: assert property (p_par) else $error("bad parameter number");
  property p_par_only;
    s_take ##0 req_space != fwm_pkg::FWM_SP_HOLD |=> !par_req;
  endproperty
  a_par_only: assert property (p_par_only) else $error("stray param");
  property p_unused;
    s_read ##0 (req_space == fwm_pkg::FWM_SP_INPUT && req_addr > 16'h00ff)
      |=> rsp_rdata == 16'h0000;
  endproperty
  a_unused: assert property (p_unused) else $error("unused not zero");
  property p_bit;
    s_read ##0 req_space[1] |=> rsp_rdata[15:1] == 15'h0000;
  endproperty
  a_bit: assert property (p_bit) else $error("bit read too wide");
  // ==================================================================
  // indicators
  // ==================================================================
  property p_ns_off;
    ce && !master_connected |=> network_status_indicator == 2'h0;
  endproperty
  a_ns_off: assert property (p_ns_off) else $error("network lit");
  property p_ns_run;
    ce && master_connected && master_run
      |=> network_status_indicator == fwm_pkg::FWM_LED_GREEN;
  endproperty
  a_ns_run: assert property (p_ns_run) else $error("network not green");
  property p_link;
    ce && !port_link[0] |=> link_indicator_0 == fwm_pkg::FWM_LED_OFF;
  endproperty
  a_link: assert property (p_link) else $error("link lit");
  property p_exc;
    ce && exception |-> ##2 (module_status_indicator == 2'h2) [*8];
  endproperty
  a_exc: assert property (p_exc) else $error("fault not red");
endmodule // fwm_map_chk

bind fwm_map fwm_map_chk chk (.clock, .rst, .ce, .req_valid, .req_write,
  .req_space, .req_addr, .rsp_valid, .rsp_rdata, .par_req, .par_num,
  .exception, .master_connected, .master_run, .port_link,
  .module_status_indicator, .network_status_indicator, .link_indicator_0);

// ==== test/fwm_net_master.sv ====
// ==================================================================
// network master: one request per call, response taken a cycle later
// ==================================================================
module fwm_net_master (
  input wire logic clock,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata,
  output logic req_valid,
  output logic req_write,
  output fwm_pkg::fwm_space_t req_space,
  output logic [15:0] req_addr,
  output logic [15:0] req_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_space = fwm_pkg::FWM_SP_HOLD;
    req_addr = 16'h0000;
    req_wdata = 16'h0000;
  end
  // sp: 0 hold, 1 input, 2 coil, 3 discrete
  task automatic access(input logic [1:0] sp, input logic wr,
      input logic [15:0] a, input logic [15:0] d, output logic [15:0] q);
    @(negedge clock);
    req_valid = 1'b1;
    req_write = wr;
    req_space = fwm_pkg::fwm_space_t'(sp);
    req_addr = a;
    req_wdata = d;
    @(negedge clock);
    q = rsp_valid ? rsp_rdata : 16'hxxxx;
    req_valid = 1'b0;
    // released lines carry garbage, not the old request
    req_addr = ~a;
    req_wdata = ~d;
  endtask
endmodule // fwm_net_master

// ==== test/test_fwm_map.sv ====
module test_fwm_map;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, rst = 1'b1, ce = 1'b1, io_rd_we = 1'b0;
  logic req_valid, req_write, rsp_valid, par_req, par_write;
  fwm_pkg::fwm_space_t req_space;
  logic [15:0] req_addr, req_wdata, rsp_rdata, io_wr_word, par_num;
  logic [15:0] par_wdata, par_rdata, io_rd_wdata = 16'h0000, q, d, e;
  logic [7:0] io_rd_index = 8'h00, io_rd_we_index = 8'h00;
  logic [6:0] st = 7'h00;
  logic master_connected = 1'b0, master_run = 1'b0;
  logic [1:0] port_link = 2'h0, port_exchange = 2'h0;
  fwm_pkg::fwm_led_t module_status_indicator, network_status_indicator;
  fwm_pkg::fwm_led_t link_indicator_0, link_indicator_1;
  logic [2:0] m_ms, m_ns, m_l0, m_l1;
  logic [31:0] seed = 32'd12;
  int fail_count = 0, checked = 0;
  always #5 clock = ~clock;
  assign par_rdata = req_addr ^ 16'h3c3c;
  fwm_map #(.TICK_CYC(4)) uut (.clock, .rst, .ce, .req_valid, .req_write,
    .req_space, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata,
    .io_rd_index, .io_wr_word, .io_rd_we, .io_rd_we_index, .io_rd_wdata,
    .par_req, .par_write, .par_num, .par_wdata, .par_rdata,
    .exception(st[6]), .self_test(st[5]), .internal_error(st[4]),
    .no_name(st[3]), .no_ip(st[2]), .cfg_error(st[1]), .identify(st[0]),
    .master_connected, .master_run, .port_link, .port_exchange,
    .module_status_indicator, .network_status_indicator,
    .link_indicator_0, .link_indicator_1);
  fwm_net_master net (.clock, .rsp_valid, .rsp_rdata, .req_valid,
    .req_write, .req_space, .req_addr, .req_wdata);
  // ==================================================================
  // helpers
  // ==================================================================
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  // holding address of a drive parameter, from its number
  function automatic logic [15:0] par_addr(input logic [15:0] n);
    return 16'h0210 + n - 16'h0001;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic rd(input logic [1:0] s, input logic [15:0] a,
      input logic [15:0] x);
    net.access(s, 1'b0, a, 16'h0000, q);
    chk(q, x);
  endtask
  task automatic wr(input logic [1:0] s, input logic [15:0] a,
      input logic [15:0] v);
    net.access(s, 1'b1, a, v, q);
  endtask
  // marks which colours each indicator showed over two and a half flash frames
  task automatic watch();
    m_ms = 3'h0;
    m_ns = 3'h0;
    m_l0 = 3'h0;
    m_l1 = 3'h0;
    repeat (3) @(negedge clock);
    repeat (160)
    begin
      @(negedge clock);
      m_ms[module_status_indicator] = 1'b1;
      m_ns[network_status_indicator] = 1'b1;
      m_l0[link_indicator_0] = 1'b1;
      m_l1[link_indicator_1] = 1'b1;
    end
  endtask
  initial
  begin
    #100us;
    fail_count++;
    stop_test();
  end
  // ==================================================================
  // tests
  // ==================================================================
  initial
  begin
    repeat (3) @(negedge clock);
    rst = 1'b0;
    for (int n = 0; n < 24; n++)
    begin
      e = n == 0 ? 16'h0fff : n == 1 ? 16'h0000 : rnd();
      d = rnd();
      wr(0, {8'h00, e[7:0]}, d);
      rd(0, {8'h00, e[7:0]}, d);
      rd(2, {4'h0, e[7:0], e[11:8]}, {15'h0, d[e[11:8]]});
      wr(2, {4'h0, e[7:0], e[11:8]}, {15'h0, ~d[e[11:8]]});
      d[e[11:8]] = ~d[e[11:8]];
      io_rd_index = e[7:0];
      @(negedge clock);
      chk(io_wr_word, d);
      @(negedge clock);
      io_rd_we = 1'b1;
      io_rd_we_index = e[7:0];
      io_rd_wdata = ~d;
      @(negedge clock);
      io_rd_we = 1'b0;
      wr(0, {8'h01, e[7:0]}, d);
      wr(1, {8'h00, e[7:0]}, d);
      rd(0, {8'h01, e[7:0]}, ~d);
      rd(1, {8'h00, e[7:0]}, ~d);
      rd(3, {4'h0, e[7:0], e[11:8]}, {15'h0, ~d[e[11:8]]});
    end
    $display("word map test done");
    rd(0, 16'h0212, 16'h0212 ^ 16'h3c3c);
    chk(par_num, 16'h0003);
    chk({15'h0000, par_write}, 16'h0000);
    rd(0, 16'hffff, 16'hffff ^ 16'h3c3c);
    wr(0, 16'h0273, 16'h1234);
    chk(par_num, 16'h0064);
    chk(par_wdata, 16'h1234);
    chk({15'h0000, par_write}, 16'h0001);
    chk({15'h0000, par_req}, 16'h0001);
    for (int n = 0; n < 8; n++)
    begin
      e = rnd();
      d = {7'h00, e[8:0]} + 16'h0001;
      rd(0, par_addr(d), par_addr(d) ^ 16'h3c3c);
      chk(par_num, d);
    end
    rd(0, 16'h0200, 16'h0000);
    rd(1, 16'h0210, 16'h0000);
    chk({15'h0000, par_req}, 16'h0000);
    rd(2, 16'h1000, 16'h0000);
    rd(3, 16'hffff, 16'h0000);
    $display("parameter and unused test done");
    master_connected = 1'b1;
    port_link = 2'h3;
    port_exchange = 2'h1;
    for (int k = 0; k < 6; k++)
    begin
      st = 7'(1 << k);
      watch();
      chk(m_ms, k == 0 ? 3'h3 : k == 5 ? 3'h6 : 3'h5);
    end
    chk(m_ns, 3'h3);
    chk(m_l0, 3'h3);
    chk(m_l1, 3'h2);
    // clock enable low must freeze the self-test alternation
    ce = 1'b0;
    e = {14'h0000, module_status_indicator};
    repeat (20) @(negedge clock);
    chk({14'h0000, module_status_indicator}, e);
    ce = 1'b1;
    st = 7'h23;
    watch();
    chk(m_ms, 3'h6);
    st = 7'h03;
    watch();
    chk(m_ms, 3'h5);
    master_run = 1'b1;
    port_link = 2'h1;
    st = 7'h41;
    watch();
    chk(m_ns, 3'h2);
    chk(m_l1, 3'h1);
    chk(m_ms, 3'h4);
    st = 7'h00;
    watch();
    chk(m_ms, 3'h4);
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    watch();
    chk(m_ms, 3'h2);
    $display("indicator test done");
    stop_test();
  end
endmodule // test_fwm_map
